// >>> rtl/ibh_pkg.sv
// Functional notes
// R1 - done flag set holds clock low
// R2 - writing one clears flag, starts selected operation
// R3 - software loads registers while flag set
// R4 - control written last, flag bit set
// R5 - transfer suspended while flag set
// R6 - software masks low status bits
// R7 - software waits flag, compares status
// R8 - send byte: load data, clear flag
// R9 - four modes: mt, mr, st, sr
// R10 - software decides permitted modes
// R11 - direction bit high read, low write
// R12 - ack low, nack high
// R13 - no flag after sending stop
// R14 - status updated cycle after flag
// R15 - no new operation while flag set
// R16 - flag clear gives no-status code
package ibh_pkg;
	// ==========================================================
	// control register bits
	localparam int CTRL_FLAG  = 7;
	localparam int CTRL_ACKEN = 6;
	localparam int CTRL_STA   = 5;
	localparam int CTRL_STO   = 4;
	localparam int CTRL_EN    = 2;
	// ==========================================================
	// status codes
	localparam logic [7:0] ST_START     = 8'h08;
	localparam logic [7:0] ST_RSTART    = 8'h10;
	localparam logic [7:0] ST_ADDR_ACK  = 8'h18;
	localparam logic [7:0] ST_ADDR_NACK = 8'h20;
	localparam logic [7:0] ST_DATA_ACK  = 8'h28;
	localparam logic [7:0] ST_DATA_NACK = 8'h30;
	localparam logic [7:0] ST_MR_ADDR_ACK  = 8'h40;
	localparam logic [7:0] ST_MR_ADDR_NACK = 8'h48;
	localparam logic [7:0] ST_MR_DATA_ACK  = 8'h50;
	localparam logic [7:0] ST_MR_DATA_NACK = 8'h58;
	localparam logic [7:0] ST_SR_ADDR   = 8'h60;
	localparam logic [7:0] ST_SR_DATA_ACK  = 8'h80;
	localparam logic [7:0] ST_SR_DATA_NACK = 8'h88;
	localparam logic [7:0] ST_SR_STOP   = 8'ha0;
	localparam logic [7:0] ST_ST_ADDR   = 8'ha8;
	localparam logic [7:0] ST_ST_DATA_ACK  = 8'hb8;
	localparam logic [7:0] ST_ST_DATA_NACK = 8'hc0;
	localparam logic [7:0] ST_NONE      = 8'hf8;
	// ==========================================================
	// timing: half period of generated clock, in cycles
	localparam int          SCL_HALF_NS  = 80;
	localparam int          CLK_NS       = 5;
	localparam logic [9:0]  SCL_HALF_CYC =
		10'((SCL_HALF_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [6:0]  OWN_ADDR_RST = 7'h00;
	// ==========================================================
	// sequencer states
	typedef enum logic [3:0] {
		IBH_IDLE  = 4'h0,
		IBH_STA1  = 4'h1,
		IBH_BITL  = 4'h3,
		IBH_BITH  = 4'h2,
		IBH_HOLD  = 4'h6,
		IBH_STO1  = 4'h7,
		IBH_STO2  = 4'h5,
		IBH_SLAVE = 4'h4,
		IBH_SWAIT = 4'hc
	} ibh_state_t;
endpackage

// >>> rtl/ibh_sync.sv
module ibh_sync (
	input  wire logic clk_in,
	input  wire logic reset_in,
	input  wire logic d_in,
	output logic      q_out
);
	logic s1_q;
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			s1_q  <= 1'b1;
			q_out <= 1'b1;
		end else begin
			s1_q  <= d_in;
			q_out <= s1_q;
		end
	end
endmodule

// >>> rtl/ibh_core.sv
module ibh_core (
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	input  wire logic [7:0] ctrl_wdata_in,
	input  wire logic       ctrl_we_in,
	input  wire logic [7:0] data_wdata_in,
	input  wire logic       data_we_in,
	input  wire logic [6:0] own_addr_in,
	output logic      [7:0] ctrl_reg_out,
	output logic      [7:0] xfer_data_reg_out,
	output logic      [7:0] status_code_reg_out,
	output logic            done_flag_out,
	output logic            wcol_out,
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe_n_out,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n_out
);
	// ==========================================================
	// pin synchronisers
	logic scl_s, sda_s, scl_p_q, sda_p_q;
	ibh_sync u_scl (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.d_in     (scl_in),
		.q_out    (scl_s)
	);
	ibh_sync u_sda (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.d_in     (sda_in),
		.q_out    (sda_s)
	);
	wire scl_rise = scl_s & ~scl_p_q;
	wire scl_fall = ~scl_s & scl_p_q;
	wire bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
	wire bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;
	// ==========================================================
	// registers and state
	ibh_pkg::ibh_state_t st_q;
	logic [7:0] ctrl_q, data_q, stat_q, code_q;
	logic [7:0] sh_q;
	logic [3:0] bit_q;
	logic [9:0] tick_q;
	logic       flag_q, flag_p_q, wcol_q;
	logic       master_q, tx_q, addr_ph_q, rd_q, scl_lo_q, sda_lo_q;
	logic       op_go;
	wire        tick_done = (tick_q == 10'h000);
	wire        en        = ctrl_q[ibh_pkg::CTRL_EN];
	// flag clear by software write with flag bit one
	wire        sw_clr = ctrl_we_in &
		ctrl_wdata_in[ibh_pkg::CTRL_FLAG]; // R2
	logic       hw_set;
	logic [7:0] hw_code;
	// operation launches only once flag is clear
	assign op_go = ~flag_q & ~flag_p_q; // R15
	// ==========================================================
	// flag: set wins over clear
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			flag_q   <= 1'b0;
			flag_p_q <= 1'b0;
			code_q   <= ibh_pkg::ST_NONE;
		end else begin
			flag_p_q <= sw_clr & flag_q;
			if (hw_set) begin
				flag_q <= 1'b1; // R1
				code_q <= hw_code;
			end else if (sw_clr) begin
				flag_q <= 1'b0; // R2
			end
		end
	end
	// status follows flag one cycle later
	always_ff @(posedge clk_in) begin
		if (reset_in) stat_q <= ibh_pkg::ST_NONE;
		else stat_q <= flag_q ? code_q : ibh_pkg::ST_NONE; // R14 R16
	end
	// ==========================================================
	// software registers
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			ctrl_q <= 8'h00;
			data_q <= 8'h00;
			wcol_q <= 1'b0;
		end else begin
			if (ctrl_we_in) ctrl_q <= {1'b0, ctrl_wdata_in[6:0]};
			if (data_we_in & flag_q) data_q <= data_wdata_in; // R3
			else if (data_we_in) wcol_q <= 1'b1;
			else if (ctrl_we_in) wcol_q <= 1'b0;
			if (st_q == ibh_pkg::IBH_HOLD && !tx_q && !hw_set &&
				bit_q == 4'h8) data_q <= sh_q;
			if (st_q == ibh_pkg::IBH_BITL && !tx_q && bit_q == 4'h8)
				data_q <= sh_q; // R9
			if (st_q == ibh_pkg::IBH_STO2 && tick_done)
				ctrl_q[ibh_pkg::CTRL_STO] <= 1'b0;
		end
	end
	// ==========================================================
	// status code of finished byte
	function automatic logic [7:0] byte_code(input logic m,
		input logic a, input logic r, input logic t, input logic n);
		if (m && a) byte_code = r ? (n ? ibh_pkg::ST_MR_ADDR_NACK :
			ibh_pkg::ST_MR_ADDR_ACK) : (n ? ibh_pkg::ST_ADDR_NACK :
			ibh_pkg::ST_ADDR_ACK);
		else if (m) byte_code = t ? (n ? ibh_pkg::ST_DATA_NACK :
			ibh_pkg::ST_DATA_ACK) : (n ? ibh_pkg::ST_MR_DATA_NACK :
			ibh_pkg::ST_MR_DATA_ACK);
		else byte_code = t ? (n ? ibh_pkg::ST_ST_DATA_NACK :
			ibh_pkg::ST_ST_DATA_ACK) : (n ? ibh_pkg::ST_SR_DATA_NACK :
			ibh_pkg::ST_SR_DATA_ACK);
	endfunction
	// ==========================================================
	// sequencer
	wire ack_bit = sh_q[0];
	always_comb begin
		hw_set  = 1'b0;
		hw_code = ibh_pkg::ST_NONE;
		case (st_q)
		ibh_pkg::IBH_STA1: if (tick_done && sda_lo_q) begin
			hw_set  = 1'b1;
			hw_code = master_q ? ibh_pkg::ST_RSTART : ibh_pkg::ST_START;
		end
		ibh_pkg::IBH_HOLD: if (bit_q == 4'h9) begin
			hw_set = 1'b1; // R9
			hw_code = addr_ph_q ? (master_q ?
				byte_code(1'b1, 1'b1, rd_q, tx_q, ack_bit) :
				(rd_q ? ibh_pkg::ST_ST_ADDR : ibh_pkg::ST_SR_ADDR)) :
				byte_code(master_q, 1'b0, rd_q, tx_q, ack_bit);
		end
		ibh_pkg::IBH_SLAVE: if (bus_stop && !master_q) begin
			hw_set  = 1'b1;
			hw_code = ibh_pkg::ST_SR_STOP;
		end
		default: ;
		endcase
	end
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st_q <= ibh_pkg::IBH_IDLE;
			{master_q, tx_q, addr_ph_q, rd_q} <= 4'h0;
			{scl_lo_q, sda_lo_q} <= 2'b00;
			sh_q <= 8'h00;
			bit_q <= 4'h0;
			tick_q <= 10'h000;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
			tick_q <= tick_done ? 10'h000 : tick_q - 10'h001;
			case (st_q)
			ibh_pkg::IBH_IDLE: begin
				{scl_lo_q, sda_lo_q} <= 2'b00;
				if (en && op_go && ctrl_q[ibh_pkg::CTRL_STA]) begin
					st_q <= ibh_pkg::IBH_STA1;
					sda_lo_q <= 1'b1;
					tick_q <= ibh_pkg::SCL_HALF_CYC;
				end else if (en && bus_start) begin
					st_q <= ibh_pkg::IBH_SLAVE;
					{addr_ph_q, tx_q, master_q} <= 3'b100;
					bit_q <= 4'h0;
				end
			end
			ibh_pkg::IBH_STA1: if (tick_done && !sda_lo_q) begin
				sda_lo_q <= 1'b1;
				tick_q <= ibh_pkg::SCL_HALF_CYC;
			end else if (tick_done) begin
				scl_lo_q <= 1'b1;
				{master_q, addr_ph_q} <= 2'b11;
				st_q <= ibh_pkg::IBH_SWAIT;
			end
			ibh_pkg::IBH_SWAIT: begin
				scl_lo_q <= 1'b1; // R1 R5
				if (op_go && en) begin
					if (ctrl_q[ibh_pkg::CTRL_STO]) begin
						st_q <= ibh_pkg::IBH_STO1;
						sda_lo_q <= 1'b1;
						tick_q <= ibh_pkg::SCL_HALF_CYC;
					end else if (ctrl_q[ibh_pkg::CTRL_STA]
						&& !addr_ph_q) begin
						{scl_lo_q, sda_lo_q} <= 2'b00;
						tick_q <= ibh_pkg::SCL_HALF_CYC;
						st_q <= ibh_pkg::IBH_STA1;
					end else begin
						if (addr_ph_q) rd_q <= data_q[0]; // R11
						tx_q <= addr_ph_q | ~rd_q;
						sh_q <= data_q;
						bit_q <= 4'h0;
						tick_q <= ibh_pkg::SCL_HALF_CYC;
						st_q <= ibh_pkg::IBH_BITL;
					end
				end
			end
			ibh_pkg::IBH_BITL: begin
				scl_lo_q <= 1'b1;
				if (bit_q < 4'h8) sda_lo_q <= tx_q & ~sh_q[7];
				else sda_lo_q <= ~tx_q &
					ctrl_q[ibh_pkg::CTRL_ACKEN]; // R12
				if (tick_done) begin
					scl_lo_q <= 1'b0;
					tick_q <= ibh_pkg::SCL_HALF_CYC;
					st_q <= ibh_pkg::IBH_BITH;
				end
			end
			ibh_pkg::IBH_BITH: if (tick_done && scl_s) begin
				sh_q <= (bit_q < 4'h8) ? {sh_q[6:0], sda_s}
					: {sh_q[7:1], sda_s};
				bit_q <= bit_q + 4'h1;
				scl_lo_q <= 1'b1;
				tick_q <= ibh_pkg::SCL_HALF_CYC;
				st_q <= (bit_q == 4'h8) ? ibh_pkg::IBH_HOLD
					: ibh_pkg::IBH_BITL;
			end
			ibh_pkg::IBH_HOLD: begin
				bit_q <= 4'h9;
				sda_lo_q <= 1'b0;
				if (bit_q == 4'h9) begin
					addr_ph_q <= 1'b0;
					st_q <= ibh_pkg::IBH_SWAIT;
				end
			end
			ibh_pkg::IBH_STO1: if (tick_done) begin
				scl_lo_q <= 1'b0;
				tick_q <= ibh_pkg::SCL_HALF_CYC;
				st_q <= ibh_pkg::IBH_STO2;
			end
			ibh_pkg::IBH_STO2: if (tick_done) begin
				sda_lo_q <= 1'b0; // R13
				master_q <= 1'b0;
				st_q <= ibh_pkg::IBH_IDLE;
			end
			ibh_pkg::IBH_SLAVE: begin
				if (bus_stop) st_q <= ibh_pkg::IBH_IDLE;
				else if (scl_rise) begin
					sh_q <= {sh_q[6:0], sda_s};
					bit_q <= bit_q + 4'h1;
				end else if (scl_fall && bit_q == 4'h8) begin
					rd_q <= sh_q[0];
					if (sh_q[7:1] == own_addr_in) begin
						st_q <= ibh_pkg::IBH_HOLD;
						bit_q <= 4'h8;
						scl_lo_q <= 1'b1;
					end else st_q <= ibh_pkg::IBH_IDLE;
				end
			end
			default: st_q <= ibh_pkg::IBH_IDLE;
			endcase
		end
	end
	// ==========================================================
	// outputs
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			ctrl_reg_out        <= 8'h00;
			xfer_data_reg_out   <= 8'h00;
			status_code_reg_out <= ibh_pkg::ST_NONE;
			done_flag_out       <= 1'b0;
			wcol_out            <= 1'b0;
			scl_oe_n_out        <= 1'b1;
			sda_oe_n_out        <= 1'b1;
			scl_out             <= 1'b0;
			sda_out             <= 1'b0;
		end else begin
			ctrl_reg_out        <= {flag_q, ctrl_q[6:0]};
			xfer_data_reg_out   <= data_q;
			status_code_reg_out <= stat_q;
			done_flag_out       <= flag_q;
			wcol_out            <= wcol_q;
			scl_oe_n_out        <= ~(scl_lo_q | flag_q); // R1
			sda_oe_n_out        <= ~sda_lo_q;
			scl_out             <= 1'b0;
			sda_out             <= 1'b0;
		end
	end
	// ==========================================================
	// checks
	AST_HOLD_LOW: assert property (@(posedge clk_in) disable iff
		(reset_in) flag_q |=> !scl_oe_n_out) // R1
		else $error("clock not held low while flag set");
	AST_CLEAR: assert property (@(posedge clk_in) disable iff
		(reset_in) (sw_clr && !hw_set) |=> !flag_q) // R2
		else $error("flag not cleared by write");
	AST_STAT_NEXT: assert property (@(posedge clk_in) disable iff
		(reset_in) $rose(flag_q) |=> stat_q == code_q) // R14
		else $error("status not updated after flag");
	AST_NO_STAT: assert property (@(posedge clk_in) disable iff
		(reset_in) !flag_q |=> stat_q == ibh_pkg::ST_NONE) // R16
		else $error("status not idle code");
	AST_SUSPEND: assert property (@(posedge clk_in) disable iff
		(reset_in) (flag_q && st_q == ibh_pkg::IBH_SWAIT)
		|=> st_q == ibh_pkg::IBH_SWAIT) // R5 R15
		else $error("transfer moved while flag set");
	AST_STOP_NOFLAG: assert property (@(posedge clk_in) disable iff
		(reset_in) (st_q == ibh_pkg::IBH_STO2) |=> !flag_q) // R13
		else $error("flag set after stop");
endmodule

// >>> tb/ibh_slave_model.sv
module ibh_slave_model #(
	parameter logic [6:0] ADDR    = 7'h5a,
	parameter logic [7:0] RD_BYTE = 8'h96
) (
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_oe_n_out,
	output logic [7:0]      byte_out,
	output logic            rw_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// bus follower
	int         bitn  = 0;
	int         phase = 0;
	logic [7:0] sh    = 8'h00;
	logic       mack  = 1'b1;
	initial begin
		sda_oe_n_out = 1'b1;
		byte_out = 8'h00;
		rw_out = 1'b0;
	end
	always @(negedge sda_in) if (scl_in === 1'b1) begin
		phase = 1;
		bitn = -1;
		sda_oe_n_out = 1'b1;
	end
	always @(posedge sda_in) if (scl_in === 1'b1) begin
		phase = 0;
		sda_oe_n_out = 1'b1;
	end
	always @(posedge scl_in) if (phase != 0) begin
		if (bitn < 8)
			sh = {sh[6:0], sda_in};
		else
			mack = sda_in;
	end
	// ==========================================================
	// ack slot, direction and read data
	always @(negedge scl_in) if (phase != 0) begin
		bitn = bitn + 1;
		sda_oe_n_out = 1'b1;
		if (bitn == 8 && phase == 1) begin
			sda_oe_n_out = (sh[7:1] != ADDR);
			rw_out = sh[0];
		end else if (bitn == 8 && phase == 2) begin
			sda_oe_n_out = 1'b0;
			byte_out = sh;
		end else if (bitn == 9) begin
			bitn = 0;
			if (phase == 1)
				phase = (sh[7:1] != ADDR) ? 0 : (sh[0] ? 3 : 2);
			else if (phase == 3 && mack)
				phase = 0;
		end
		if (phase == 3 && bitn < 8)
			sda_oe_n_out = RD_BYTE[7 - bitn];
	end
endmodule

// >>> tb/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [6:0] ADDR = 7'h5a;
	localparam logic [7:0] RDB  = 8'h96;
	logic        clk       = 1'b0;
	logic        rst       = 1'b1;
	logic [7:0]  cw        = 8'h00;
	logic        cwe       = 1'b0;
	logic [7:0]  dw        = 8'h00;
	logic        dwe       = 1'b0;
	logic [7:0]  xdat;
	logic [7:0]  stat;
	logic        flag;
	logic        scl_oe_n;
	logic        sda_oe_n;
	logic        m_oe_n;
	logic [7:0]  m_byte;
	logic        m_rw;
	logic [7:0]  ctrl;
	logic        wcol;
	logic [1:0]  pins;
	logic        f1        = 1'b0;
	logic        f2        = 1'b0;
	logic        hold_bad  = 1'b0;
	logic [31:0] seed      = 32'h9bae9f46;
	logic [7:0]  exp_q[$];
	int          error_cnt = 0;
	int          checks    = 0;
	wire         scl_w     = scl_oe_n;
	wire         sda_w     = sda_oe_n & m_oe_n;
	always #2.5 clk = ~clk;
	ibh_core ibh_core_inst (.clk_in(clk), .reset_in(rst),
		.ctrl_wdata_in(cw), .ctrl_we_in(cwe), .data_wdata_in(dw),
		.data_we_in(dwe), .own_addr_in(7'h11), .ctrl_reg_out(ctrl),
		.xfer_data_reg_out(xdat), .status_code_reg_out(stat),
		.done_flag_out(flag), .wcol_out(wcol), .scl_in(scl_w),
		.scl_out(pins[1]), .scl_oe_n_out(scl_oe_n), .sda_in(sda_w),
		.sda_out(pins[0]), .sda_oe_n_out(sda_oe_n));
	ibh_slave_model #(.ADDR(ADDR), .RD_BYTE(RDB)) ibh_slave_model_inst (
		.scl_in(scl_w), .sda_in(sda_w), .sda_oe_n_out(m_oe_n),
		.byte_out(m_byte), .rw_out(m_rw));
	// ==========================================================
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] v, input logic d);
		@(posedge clk);
		#1;
		if (d)
			dw = v;
		else
			cw = v;
		dwe = d;
		cwe = !d;
		@(posedge clk);
		#1;
		dwe = 1'b0;
		cwe = 1'b0;
	endtask
	task automatic op(input logic [7:0] c, input logic [7:0] e);
		int n;
		n = 0;
		exp_q.push_back(e);
		wr(c, 1'b0);
		// flag output drops one cycle after the write
		@(posedge clk);
		#1;
		while (flag !== 1'b1 && n < 12000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("done flag", 8'h01, {7'h00, flag});
		repeat (3) @(posedge clk);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========================================================
	// result watcher
	always @(posedge clk) begin
		f1 <= flag;
		f2 <= f1;
		if (f1 === 1'b1 && f2 === 1'b0) begin
			if (exp_q.size() == 0)
				chk("unexpected flag", 8'h00, 8'h01);
			else
				chk("status", exp_q.pop_front(), stat & 8'hf8);
		end
	end
	initial begin
		#100000;
		error_cnt++;
		$display("[FAIL] watchdog expected done seen timeout");
		summarize();
	end
	// ==========================================================
	// tests
	initial begin
		repeat (8) @(posedge clk);
		#1;
		rst = 1'b0;
		chk("reset status", ibh_pkg::ST_NONE, stat);
		op(8'ha4, ibh_pkg::ST_START);
		wr(8'h04, 1'b0);
		repeat (1200) begin
			@(posedge clk);
			#1;
			if (scl_w !== 1'b0 || flag !== 1'b1)
				hold_bad = 1'b1;
		end
		chk("scl hold", 8'h00, {7'h00, hold_bad});
		$display("test start_hold done");
		wr({ADDR, 1'b0}, 1'b1);
		op(8'h84, ibh_pkg::ST_ADDR_ACK);
		chk("rw bit", 8'h00, {7'h00, m_rw});
		for (int i = 0; i < 2; i++) begin
			seed = xs(seed);
			wr(seed[7:0], 1'b1);
			op(8'h84, ibh_pkg::ST_DATA_ACK);
			chk("slave byte", seed[7:0], m_byte);
		end
		$display("test master_write done");
		op(8'ha4, ibh_pkg::ST_RSTART);
		wr({ADDR ^ 7'h01, 1'b0}, 1'b1);
		op(8'h84, ibh_pkg::ST_ADDR_NACK);
		op(8'ha4, ibh_pkg::ST_RSTART);
		wr({ADDR, 1'b1}, 1'b1);
		op(8'h84, ibh_pkg::ST_MR_ADDR_ACK);
		chk("rw bit", 8'h01, {7'h00, m_rw});
		op(8'h84, ibh_pkg::ST_MR_DATA_NACK);
		chk("read byte", RDB, xdat);
		$display("test master_read done");
		wr(8'h94, 1'b0);
		repeat (3000) @(posedge clk);
		#1;
		chk("bus idle", 8'h03, {6'h00, scl_w, sda_w});
		chk("flag idle", 8'h00, {7'h00, flag});
		chk("status idle", ibh_pkg::ST_NONE, stat);
		chk("ctrl reg", 8'h04, ctrl);
		chk("pin level", 8'h00, {6'h00, pins});
		wr(8'h3c, 1'b1);
		repeat (2) @(posedge clk);
		#1;
		chk("collision", 8'h01, {7'h00, wcol});
		chk("data kept", RDB, xdat);
		wr(8'h04, 1'b0);
		repeat (2) @(posedge clk);
		#1;
		chk("collision clr", 8'h00, {7'h00, wcol});
		$display("test stop done");
		summarize();
	end
endmodule
